// [src/lemc_pkg.sv]
package lemc_pkg;

  // ----------------------------------------------------------------
  // control register 0 layout
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned LASER_OFF_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h04;

  // ----------------------------------------------------------------
  // pattern table layout
  // ----------------------------------------------------------------
  localparam int unsigned PULSE_W = 3;
  localparam int unsigned ENTRY_W = 8;
  localparam int unsigned ROI_BIT = 7;
  localparam int unsigned LINE_AW = 10;

  typedef enum logic [1:0] {
    LEMC_ST_RESET = 2'h1,
    LEMC_ST_RUN = 2'h2
  } lemc_state_e;

  typedef struct packed {
    logic wr;
    logic [LINE_AW-1:0] addr;
    logic [ENTRY_W-1:0] data;
  } lemc_table_wr_s;

  typedef struct packed {
    logic laser_power_on;
    logic [PULSE_W-1:0] laser_pulse_out;
    logic vertical_window_gate;
  } lemc_laser_s;

endpackage : lemc_pkg

// [src/lemc_ctrl.sv]
`timescale 1ns/1ps

module lemc_ctrl #(
  parameter int unsigned LINES = 1024
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_data,
  input wire lemc_pkg::lemc_table_wr_s table_wr,
  input wire logic [lemc_pkg::LINE_AW-1:0] line_idx,
  input wire logic [1:0] channel_sel,
  input wire logic field_restart,
  output lemc_pkg::lemc_laser_s laser
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    lemc_pkg::lemc_state_e st;
    logic [7:0] ctrl;
    logic [lemc_pkg::ENTRY_W-1:0] entry;
    lemc_pkg::lemc_laser_s out;
  } lemc_regs_s;

  logic rst_meta_q;
  logic rst_sync_q;
  lemc_regs_s s_q;
  lemc_regs_s s_d;
  logic [lemc_pkg::ENTRY_W-1:0] table_q [LINES];

  // reset enters at once but leaves on a clock edge, two flops later
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // vertical pattern table, host writes only between acquisitions
  // ----------------------------------------------------------------
  // no reset here: clearing every entry would cost a wide reset tree
  always_ff @(posedge core_clk) begin
    if (table_wr.wr) begin
      table_q[table_wr.addr] <= table_wr.data;
    end
  end

  function automatic logic laser_off(input logic [7:0] c);
    laser_off = c[lemc_pkg::LASER_OFF_BIT];
  endfunction : laser_off

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // channel_sel is deliberately unused: all lasers stay live
    s_d.entry = table_q[line_idx];
    case (s_q.st)
      lemc_pkg::LEMC_ST_RESET: begin
        s_d.st = lemc_pkg::LEMC_ST_RUN;
      end
      lemc_pkg::LEMC_ST_RUN: begin
        if (ctrl_wr) begin
          s_d.ctrl = ctrl_data;
        end
      end
      default: begin
        s_d.st = lemc_pkg::LEMC_ST_RESET;
      end
    endcase
    s_d.out.laser_power_on = !laser_off(s_q.ctrl);
    s_d.out.laser_pulse_out =
      s_q.entry[lemc_pkg::PULSE_W-1:0] &
      {lemc_pkg::PULSE_W{!laser_off(s_q.ctrl)}};
    s_d.out.vertical_window_gate = s_q.entry[lemc_pkg::ROI_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q.st <= lemc_pkg::LEMC_ST_RESET;
      s_q.ctrl <= lemc_pkg::CTRL_RESET;
      s_q.entry <= '0;
      s_q.out <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign laser = s_q.out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_power_inv;
    @(posedge core_clk) disable iff (!rst_sync_q)
    laser.laser_power_on == !$past(s_q.ctrl[lemc_pkg::LASER_OFF_BIT]);
  endproperty
  a_power_inv: assert property (p_power_inv) else $error("power on bad");

  property p_reset_low;
    @(posedge core_clk) $rose(rst_sync_q) |-> !laser.laser_power_on;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("power not low");

  property p_pulse_gate;
    @(posedge core_clk) disable iff (!rst_sync_q)
    laser.laser_pulse_out == ($past(s_q.entry[lemc_pkg::PULSE_W-1:0]) &
      {lemc_pkg::PULSE_W{!$past(s_q.ctrl[lemc_pkg::LASER_OFF_BIT])}});
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("pulse bad");

  property p_chan_free;
    @(posedge core_clk) disable iff (!rst_sync_q)
    $stable(line_idx) && !table_wr.wr && !ctrl_wr ##1
      $stable(line_idx) && !table_wr.wr && !ctrl_wr && $changed(channel_sel)
      |-> ##2 $stable(laser.laser_pulse_out);
  endproperty
  a_chan_free: assert property (p_chan_free) else $error("chan gated");

  property p_gate_src;
    @(posedge core_clk) disable iff (!rst_sync_q)
    laser.vertical_window_gate == $past(s_q.entry[lemc_pkg::ROI_BIT]);
  endproperty
  a_gate_src: assert property (p_gate_src) else $error("gate bad");

  property p_off_reset;
    @(posedge core_clk) $rose(rst_sync_q) |->
      s_q.ctrl[lemc_pkg::LASER_OFF_BIT] && laser.laser_pulse_out == '0;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("off not set");

  property p_enable_rise;
    @(posedge core_clk) disable iff (!rst_sync_q)
    ctrl_wr && !ctrl_data[lemc_pkg::LASER_OFF_BIT] &&
      s_q.st == lemc_pkg::LEMC_ST_RUN |-> ##2 laser.laser_power_on;
  endproperty
  a_enable_rise: assert property (p_enable_rise) else $error("no rise");

  // ----------------------------------------------------------------
  // control register and state checks
  // ----------------------------------------------------------------
  property p_ctrl_take;
    @(posedge core_clk) disable iff (!rst_sync_q)
    ctrl_wr && s_q.st == lemc_pkg::LEMC_ST_RUN |=>
      s_q.ctrl == $past(ctrl_data);
  endproperty
  a_ctrl_take: assert property (p_ctrl_take) else $error("ctrl lost");

  property p_ctrl_hold;
    @(posedge core_clk) disable iff (!rst_sync_q)
    !(ctrl_wr && s_q.st == lemc_pkg::LEMC_ST_RUN) |=> $stable(s_q.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("ctrl moved");

  // the power output may only move two edges after a write
  property p_power_follow;
    @(posedge core_clk) disable iff (!rst_sync_q)
    $changed(laser.laser_power_on) |-> $past(ctrl_wr, 2);
  endproperty
  a_power_follow: assert property (p_power_follow)
    else $error("power changed without a write");

  property p_off_quiet;
    @(posedge core_clk) disable iff (!rst_sync_q)
    s_q.ctrl[lemc_pkg::LASER_OFF_BIT] |=>
      !laser.laser_power_on && laser.laser_pulse_out == '0;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("laser live");

  property p_run_after;
    @(posedge core_clk) disable iff (!rst_sync_q)
    $past(rst_sync_q) |-> s_q.st == lemc_pkg::LEMC_ST_RUN;
  endproperty
  a_run_after: assert property (p_run_after) else $error("not running");

  // ----------------------------------------------------------------
  // pattern table checks
  // ----------------------------------------------------------------
  property p_table_wr;
    @(posedge core_clk) disable iff (!rst_sync_q)
    table_wr.wr |=>
      table_q[$past(table_wr.addr)] == $past(table_wr.data);
  endproperty
  a_table_wr: assert property (p_table_wr) else $error("entry lost");

  // only lines with a written entry are defined, the table has no reset
  property p_entry_src;
    @(posedge core_clk) disable iff (!rst_sync_q)
    $past(rst_sync_q) |-> s_q.entry == $past(table_q[line_idx]);
  endproperty
  a_entry_src: assert property (p_entry_src) else $error("entry bad");

  // window gate is not masked by the laser-off bit
  property p_gate_live;
    @(posedge core_clk) disable iff (!rst_sync_q)
    s_q.ctrl[lemc_pkg::LASER_OFF_BIT] && s_q.entry[lemc_pkg::ROI_BIT] |=>
      laser.vertical_window_gate;
  endproperty
  a_gate_live: assert property (p_gate_live) else $error("gate masked");

  // each pulse bit needs both its pattern bit and the laser enabled
  for (genvar g = 0; g < lemc_pkg::PULSE_W; g++) begin : g_pulse_chk
    property p_pulse_bit;
      @(posedge core_clk) disable iff (!rst_sync_q)
      laser.laser_pulse_out[g] |->
        $past(s_q.entry[g]) && !$past(s_q.ctrl[lemc_pkg::LASER_OFF_BIT]);
    endproperty
    a_pulse_bit: assert property (p_pulse_bit) else $error("pulse src");
  end

  c_enable: cover property (@(posedge core_clk) $rose(laser.laser_power_on));
  c_pulse: cover property (@(posedge core_clk) laser.laser_pulse_out == 3'h7);
  c_gate: cover property (@(posedge core_clk) laser.vertical_window_gate);
  c_field: cover property (@(posedge core_clk) field_restart);

endmodule : lemc_ctrl

// [testbench/lemc_laser_model.sv]
`timescale 1ns/1ps
// ------------------------------
// sensor laser side
// ------------------------------
module lemc_laser_model (
  input wire logic core_clk,
  input wire lemc_pkg::lemc_laser_s laser,
  output logic armed
);
  logic low_q = 1'b0;
  logic armed_q = 1'b0;
  assign armed = armed_q;
  // laser only starts on a rise seen after a low
  always @(posedge core_clk) begin
    if (!laser.laser_power_on) low_q <= 1'b1;
    if (laser.laser_power_on && low_q) armed_q <= 1'b1;
  end
endmodule : lemc_laser_model

// [testbench/tb_lemc_ctrl.sv]
`timescale 1ns/1ps
module tb_lemc_ctrl;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic ctrl_wr = 1'b0;
  logic [7:0] ctrl_data = 8'h04;
  lemc_pkg::lemc_table_wr_s table_wr = '0;
  logic [9:0] line_idx = 10'h000;
  logic [1:0] channel_sel = 2'h0;
  logic field_restart = 1'b0;
  lemc_pkg::lemc_laser_s laser;
  logic armed;
  int bad_count = 0;
  int cmp_count = 0;
  always #12.5 core_clk = ~core_clk;
  lemc_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .ctrl_wr(ctrl_wr),
    .ctrl_data(ctrl_data), .table_wr(table_wr), .line_idx(line_idx),
    .channel_sel(channel_sel), .field_restart(field_restart),
    .laser(laser));
  lemc_laser_model i_laser (.core_clk(core_clk), .laser(laser),
    .armed(armed));
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic set_ctrl(input logic [7:0] v);
    @(posedge core_clk);
    ctrl_wr <= 1'b1;
    ctrl_data <= v;
    @(posedge core_clk);
    ctrl_wr <= 1'b0;
    tick(3);
  endtask : set_ctrl
  // table written only while acquisition is stopped
  task automatic put_entry(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk);
    table_wr <= '{wr: 1'b1, addr: a, data: d};
    @(posedge core_clk);
    table_wr.wr <= 1'b0;
  endtask : put_entry
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic test_enable;
    put_entry(10'h005, 8'h85);
    put_entry(10'h3FF, 8'h02);
    line_idx <= 10'h005;
    tick(4);
    check(laser, 5'h01);
    check({4'h0, armed}, 5'h00);
    set_ctrl(8'h00);
    check(laser, 5'h1B);
    check({4'h0, armed}, 5'h01);
    @(posedge core_clk);
    line_idx <= 10'h3FF;
    tick(4);
    check(laser, 5'h14);
    $display("test enable done");
  endtask : test_enable
  // lasers already pulse a field before each switch
  task automatic test_channels;
    for (int ch = 0; ch < 4; ch++) begin
      @(posedge core_clk);
      field_restart <= 1'b1;
      @(posedge core_clk);
      field_restart <= 1'b0;
      channel_sel <= 2'(ch);
      tick(3);
      check(laser, 5'h14);
    end
    $display("test channels done");
  endtask : test_channels
  task automatic test_disable;
    set_ctrl(8'hFF);
    check(laser, 5'h00);
    @(posedge core_clk);
    line_idx <= 10'h005;
    tick(4);
    check(laser, 5'h01);
    $display("test disable done");
  endtask : test_disable
  // table reloaded while held in reset, so no acquisition runs
  task automatic test_reset;
    set_ctrl(8'h00);
    check(laser, 5'h1B);
    @(posedge core_clk);
    rstn <= 1'b0;
    tick(2);
    check(laser, 5'h00);
    put_entry(10'h3FF, 8'h87);
    rstn <= 1'b1;
    tick(4);
    check(laser, 5'h01);
    set_ctrl(8'h00);
    check(laser, 5'h1B);
    @(posedge core_clk);
    line_idx <= 10'h3FF;
    tick(4);
    check(laser, 5'h1F);
    $display("test reset done");
  endtask : test_reset
  initial begin
    put_entry(10'h000, 8'h00);
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    tick(4);
    check(laser, 5'h00);
    test_enable();
    test_channels();
    test_disable();
    test_reset();
    tally_and_finish();
  end
endmodule : tb_lemc_ctrl
